// *** pssc_host.sv ***
// Host controller model on the two-wire bus, acting as bus master.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module pssc_host (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Frame opening: data falls while the clock is high
  task start;
    sda_low = 1'b1;
    #12 scl = 1'b0;
    #4;
  endtask : start
  // Frame closing: data rises while the clock is high
  task stop;
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #12 sda_low = 1'b0;
    #24;
  endtask : stop
  // One clock pulse: data set while low, sampled mid high phase
  task bit_io(input logic b, output logic r);
    sda_low = !b;
    #20 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
    #4;
  endtask : bit_io
  // Byte out MSB first, then the target's acknowledge
  task put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put
  // Byte in MSB first; last byte gets no acknowledge
  task get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : get
endmodule : pssc_host

// *** pssc_mem.sv ***
// Byte memory standing in for the separate serial EEPROM array.
// Assumes synchronous write and registered read on the core clock.
`timescale 1ns/1ps
module pssc_mem #(
  parameter int unsigned DEPTH = 128
) (
  input  wire logic  clock,
  pssc_mem_if.mem    port
);
  logic [7:0] store [DEPTH];
  logic [7:0] rd_data_ff;

  // Write port and registered read port
  always_ff @(posedge clock)
  begin
    if (port.wr_en)
    begin
      store[port.wr_addr] <= port.wr_data;
    end
    rd_data_ff <= store[port.rd_addr];
  end
  assign port.rd_data = rd_data_ff;
endmodule : pssc_mem

// *** pssc_mem_if.sv ***
// Interface between the serial target and its byte memory.
// Assumes a single clock shared by both sides.
`timescale 1ns/1ps
interface pssc_mem_if;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : pssc_mem_if

// *** pssc_pkg.sv ***
// Package for the status and control pin logic of the rectifier.
// Assumes a 200 MHz core clock and a two-wire serial target on the pins.
package pssc_pkg;
  localparam int unsigned CLK_MHZ           = 200;
  localparam logic [3:0]  CTRL_ADDR_PATTERN = 4'hB;
  localparam logic [3:0]  ROM_ADDR_PATTERN  = 4'hA;
  localparam int unsigned ROM_DEPTH         = 128;
  localparam int unsigned ROM_AW            = 7;
  localparam int unsigned CTRL_DEPTH        = 16;
  localparam logic [7:0]  CMD_ON_OFF        = 8'h01;
  localparam logic [7:0]  CMD_FW_ON         = 8'h80;
  localparam logic [7:0]  ON_OFF_DEFAULT    = 8'h80;
  localparam int unsigned SYNC_STAGES       = 2;
  typedef enum logic [2:0] {
    PSSC_IDLE, PSSC_ADDR, PSSC_ADDR_ACK, PSSC_WRITE, PSSC_WRITE_ACK,
    PSSC_READ, PSSC_READ_ACK
  } pssc_state_t;
  typedef enum logic [1:0] {PSSC_TGT_NONE, PSSC_TGT_CTRL, PSSC_TGT_ROM} pssc_tgt_t;
endpackage : pssc_pkg

// *** pssc_top.sv ***
// Status and control pin logic of the rectifier with its serial target.
// Assumes all pins but alert_event asynchronous to clock; nrst stands for bias power loss.
`timescale 1ns/1ps
module pssc_top
  import pssc_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic remote_on_in,
  input  wire logic enable_n_in,
  input  wire logic write_lock_in,
  input  wire logic slot_select_2,
  input  wire logic slot_select_1,
  input  wire logic slot_select_0,
  input  wire logic input_in_range,
  input  wire logic output_present,
  input  wire logic over_temp_trip,
  input  wire logic over_voltage_trip,
  input  wire logic over_current_trip,
  input  wire logic alert_event,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      main_output_on,
  output logic      input_good_out,
  output logic      output_good_out,
  output logic      fault_out,
  output logic      unit_inserted_out,
  output logic      alert_out,
  output logic      fw_override
);
  import pssc_pkg::*;

  localparam int unsigned NSYNC = 13;
  // Reset image of the pins: lock, slot selects, clock and data sit at their pull-up level
  localparam logic [NSYNC-1:0] SYNC_IDLE = 13'h0783;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] nxt_sync1;
  logic [NSYNC-1:0] nxt_sync2;

  // Gather asynchronous pins for the two-stage synchroniser
  assign raw_in = {remote_on_in, enable_n_in, write_lock_in, slot_select_2, slot_select_1,
                   slot_select_0, input_in_range, output_present, over_temp_trip,
                   over_voltage_trip, over_current_trip, scl_in, sda_in};

  always_comb
  begin
    nxt_sync1 = raw_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  logic       s_remote;
  logic       s_enable_n;
  logic       s_lock;
  logic [2:0] s_slot;
  logic       s_in_ok;
  logic       s_out_ok;
  logic       s_ot;
  logic       s_ov;
  logic       s_oc;
  logic       s_scl;
  logic       s_sda;
  assign {s_remote, s_enable_n, s_lock, s_slot, s_in_ok, s_out_ok, s_ot, s_ov, s_oc,
          s_scl, s_sda} = sync2_ff;

  // Serial bus edge and condition detection
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = s_scl & ~scl_d_ff;
  assign scl_fall   = ~s_scl & scl_d_ff;
  assign start_cond = s_scl & scl_d_ff & sda_d_ff & ~s_sda;
  assign stop_cond  = s_scl & scl_d_ff & ~sda_d_ff & s_sda;

  pssc_state_t state_ff;
  pssc_state_t nxt_state;
  pssc_tgt_t   tgt_ff;
  pssc_tgt_t   nxt_tgt;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_shift;
  logic [3:0]  bit_ff;
  logic [3:0]  nxt_bit;
  logic        rnw_ff;
  logic        nxt_rnw;
  logic        first_ff;
  logic        nxt_first;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic        sda_oe_ff;
  logic        nxt_sda_oe;
  logic        nack_ff;
  logic        nxt_nack;
  logic [7:0]  fw_on_off_ff;
  logic [7:0]  nxt_fw_on_off;
  logic        fw_taken_ff;
  logic        nxt_fw_taken;
  logic [7:0]  ctrl_rd;

  pssc_mem_if mem_port ();

  pssc_mem #(
    .DEPTH (ROM_DEPTH)
  ) u_mem (
    .clock (clock),
    .port  (mem_port)
  );

  // Controller readback: status bits reported only when the host asks
  always_comb
  begin
    ctrl_rd = 8'h00;
    if (ptr_ff == CMD_ON_OFF)
    begin
      ctrl_rd = fw_on_off_ff;
    end
    else
    begin
      ctrl_rd = {s_in_ok, s_out_ok, s_ot, s_ov, s_oc, main_output_on, fw_taken_ff, ~s_lock};
    end
  end

  // Serial target next-state logic
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_tgt       = tgt_ff;
    nxt_shift     = shift_ff;
    nxt_bit       = bit_ff;
    nxt_rnw       = rnw_ff;
    nxt_first     = first_ff;
    nxt_ptr       = ptr_ff;
    nxt_sda_oe    = sda_oe_ff;
    nxt_nack      = nack_ff;
    nxt_fw_on_off = fw_on_off_ff;
    nxt_fw_taken  = fw_taken_ff;
    mem_port.wr_en   = 1'b0;
    mem_port.wr_addr = ptr_ff[ROM_AW-1:0];
    mem_port.wr_data = shift_ff;
    mem_port.rd_addr = ptr_ff[ROM_AW-1:0];
    if (start_cond)
    begin
      nxt_state  = PSSC_ADDR;
      nxt_tgt    = PSSC_TGT_NONE; // Forget the last target so a stray stop clears nothing
      nxt_bit    = 4'h0;
      nxt_sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      nxt_state  = PSSC_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else
    begin
      case (state_ff)
        PSSC_IDLE:
          nxt_sda_oe = 1'b0;
        PSSC_ADDR:
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], s_sda};
            nxt_bit   = bit_ff + 4'h1;
          end
          else if (scl_fall && bit_ff == 4'h8)
          begin
            nxt_rnw   = shift_ff[0];
            nxt_first = 1'b1;
            if (shift_ff[7:1] == {CTRL_ADDR_PATTERN, s_slot})
            begin
              nxt_tgt    = PSSC_TGT_CTRL;
              nxt_state  = PSSC_ADDR_ACK;
              nxt_sda_oe = 1'b1;
            end
            else if (shift_ff[7:1] == {ROM_ADDR_PATTERN, s_slot})
            begin
              nxt_tgt    = PSSC_TGT_ROM;
              nxt_state  = PSSC_ADDR_ACK;
              nxt_sda_oe = 1'b1;
            end
            else
            begin
              nxt_state = PSSC_IDLE;
            end
          end
        PSSC_ADDR_ACK:
          if (scl_fall)
          begin
            nxt_bit = 4'h0;
            if (rnw_ff)
            begin
              nxt_state  = PSSC_READ;
              nxt_shift  = (tgt_ff == PSSC_TGT_CTRL) ? ctrl_rd : mem_port.rd_data;
              nxt_sda_oe = ~((tgt_ff == PSSC_TGT_CTRL) ? ctrl_rd[7] : mem_port.rd_data[7]);
            end
            else
            begin
              nxt_state  = PSSC_WRITE;
              nxt_sda_oe = 1'b0;
            end
          end
        PSSC_WRITE:
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], s_sda};
            nxt_bit   = bit_ff + 4'h1;
          end
          else if (scl_fall && bit_ff == 4'h8)
          begin
            nxt_state  = PSSC_WRITE_ACK;
            nxt_sda_oe = 1'b1;
            nxt_first  = 1'b0;
            if (first_ff)
            begin
              nxt_ptr = shift_ff;
            end
            else if (tgt_ff == PSSC_TGT_CTRL)
            begin
              if (ptr_ff == CMD_ON_OFF)
              begin
                nxt_fw_on_off = shift_ff;
                nxt_fw_taken  = 1'b1;
              end
            end
            else
            begin
              mem_port.wr_en = ~s_lock;
              nxt_ptr        = ptr_ff + 8'h01;
            end
          end
        PSSC_WRITE_ACK:
          if (scl_fall)
          begin
            nxt_state  = PSSC_WRITE;
            nxt_bit    = 4'h0;
            nxt_sda_oe = 1'b0;
          end
        PSSC_READ:
          if (scl_fall)
          begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7)
            begin
              nxt_state  = PSSC_READ_ACK;
              nxt_sda_oe = 1'b0;
              if (tgt_ff == PSSC_TGT_ROM)
              begin
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
            else
            begin
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        PSSC_READ_ACK:
          if (scl_rise)
          begin
            nxt_nack = s_sda;
          end
          else if (scl_fall)
          begin
            if (nack_ff)
            begin
              nxt_state = PSSC_IDLE;
            end
            else
            begin
              nxt_state  = PSSC_READ;
              nxt_bit    = 4'h0;
              nxt_shift  = (tgt_ff == PSSC_TGT_CTRL) ? ctrl_rd : mem_port.rd_data;
              nxt_sda_oe = ~((tgt_ff == PSSC_TGT_CTRL) ? ctrl_rd[7] : mem_port.rd_data[7]);
            end
          end
        default:
          nxt_state = PSSC_IDLE;
      endcase
    end
  end

  // Serial target registers; firmware state falls back to pin control on reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff     <= PSSC_IDLE;
      tgt_ff       <= PSSC_TGT_NONE;
      shift_ff     <= 8'h00;
      bit_ff       <= 4'h0;
      rnw_ff       <= 1'b0;
      first_ff     <= 1'b0;
      ptr_ff       <= 8'h00;
      sda_oe_ff    <= 1'b0;
      nack_ff      <= 1'b0;
      fw_on_off_ff <= ON_OFF_DEFAULT;
      fw_taken_ff  <= 1'b0;
      scl_d_ff     <= 1'b1;
      sda_d_ff     <= 1'b1;
    end
    else
    begin
      state_ff     <= nxt_state;
      tgt_ff       <= nxt_tgt;
      shift_ff     <= nxt_shift;
      bit_ff       <= nxt_bit;
      rnw_ff       <= nxt_rnw;
      first_ff     <= nxt_first;
      ptr_ff       <= nxt_ptr;
      sda_oe_ff    <= nxt_sda_oe;
      nack_ff      <= nxt_nack;
      fw_on_off_ff <= nxt_fw_on_off;
      fw_taken_ff  <= nxt_fw_taken;
      scl_d_ff     <= s_scl;
      sda_d_ff     <= s_sda;
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_ff;

  // Status pins, registered; high means released
  logic [5:0] stat_ff;
  logic [5:0] nxt_stat;
  logic       alert_ff;
  logic       nxt_alert;
  logic       fw_on;
  assign fw_on = (fw_on_off_ff & CMD_FW_ON) != 8'h00;

  always_comb
  begin
    nxt_stat[0] = s_remote & fw_on & ~s_enable_n;
    nxt_stat[1] = s_in_ok;
    nxt_stat[2] = s_out_ok;
    nxt_stat[3] = ~(s_ot | s_ov | s_oc | ~s_in_ok | ~s_out_ok);
    nxt_stat[4] = 1'b0;
    nxt_stat[5] = 1'b0;
    nxt_alert   = alert_ff | alert_event;
    if (stop_cond && tgt_ff == PSSC_TGT_CTRL && !alert_event)
    begin
      nxt_alert = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_ff  <= 6'h00;
      alert_ff <= 1'b0;
    end
    else
    begin
      stat_ff  <= nxt_stat;
      alert_ff <= nxt_alert;
    end
  end

  assign main_output_on    = stat_ff[0];
  assign input_good_out    = stat_ff[1];
  assign output_good_out   = stat_ff[2];
  assign fault_out         = stat_ff[3];
  assign unit_inserted_out = stat_ff[4];
  assign alert_out         = ~alert_ff;
  assign fw_override       = fw_taken_ff;
endmodule : pssc_top

// *** pssc_top_monitor.sv ***
// Checker for the status and control pin logic, bound to its top module.
// Assumes pins pass a two-stage sync, so outputs settle within three edges.
`timescale 1ns/1ps
module pssc_top_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic remote_on_in,
  input wire logic enable_n_in,
  input wire logic input_in_range,
  input wire logic output_present,
  input wire logic over_temp_trip,
  input wire logic over_voltage_trip,
  input wire logic over_current_trip,
  input wire logic alert_event,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic main_output_on,
  input wire logic input_good_out,
  input wire logic output_good_out,
  input wire logic fault_out,
  input wire logic unit_inserted_out,
  input wire logic alert_out,
  input wire logic fw_override
);
  logic any_fault;
  // Any condition that must pull the fault output low
  assign any_fault = over_temp_trip | over_voltage_trip | over_current_trip
                     | !input_in_range | !output_present;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_remote_off:
    assert property (!remote_on_in [*5] |-> !main_output_on) else $error("on with remote off");
  a_enable_off:
    assert property (enable_n_in [*5] |-> !main_output_on) else $error("on with enable open");
  a_input_good:
    assert property ($stable(input_in_range) [*5] |-> input_good_out == input_in_range)
      else $error("input good wrong");
  a_output_good:
    assert property ($stable(output_present) [*5] |-> output_good_out == output_present)
      else $error("output good wrong");
  a_fault_level:
    assert property ($stable(any_fault) [*5] |-> fault_out == !any_fault)
      else $error("fault output wrong");
  a_inserted_low:
    assert property (unit_inserted_out == 1'b0) else $error("presence not low");
  a_alert_set:
    assert property (alert_event |-> ##[1:3] !alert_out) else $error("alert not raised");
  a_override_holds:
    assert property (fw_override |=> fw_override) else $error("override lost");
  a_sda_pull:
    assert property (sda_oe |-> sda_out == 1'b0) else $error("data line driven high");
  c_override: cover property ($rose(fw_override));
  c_alert: cover property ($fell(alert_out));
  c_ack: cover property ($rose(sda_oe));
endmodule : pssc_top_monitor
bind pssc_top pssc_top_monitor pssc_top_monitor_inst (.clock, .nrst, .remote_on_in,
  .enable_n_in, .input_in_range, .output_present, .over_temp_trip, .over_voltage_trip,
  .over_current_trip, .alert_event, .sda_out, .sda_oe, .main_output_on, .input_good_out,
  .output_good_out, .fault_out, .unit_inserted_out, .alert_out, .fw_override);

// *** pssc_top_tb_top.sv ***
// Bench for the status and control pin logic with a serial host model.
// Assumes the host model masters the bus; the data line has a pull-up.
`timescale 1ns/1ps
module pssc_top_tb_top;
  import pssc_pkg::*;
  logic       clock = 0, nrst = 0, remote = 1, en_n = 0, wl = 1, alert_ev = 0;
  logic       range = 1, present = 1, ot = 0, ov = 0, oc = 0;
  logic [2:0] slot = 3'h5;
  logic       scl, sda_low, sda_out, sda_oe, main_on, in_good, out_good;
  logic       fault, inserted, alert, fw_ovr, ack;
  logic [7:0] rd;
  logic [4:0] tbl [6] = '{5'h18, 5'h08, 5'h10, 5'h1C, 5'h1A, 5'h19};
  int         bad_count = 0, checked = 0;
  wire        sda = !(sda_low | sda_oe);
  pssc_top pssc_top_inst (.clock(clock), .nrst(nrst), .remote_on_in(remote),
    .enable_n_in(en_n), .write_lock_in(wl), .slot_select_2(slot[2]),
    .slot_select_1(slot[1]), .slot_select_0(slot[0]), .input_in_range(range),
    .output_present(present), .over_temp_trip(ot), .over_voltage_trip(ov),
    .over_current_trip(oc), .alert_event(alert_ev), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .main_output_on(main_on),
    .input_good_out(in_good), .output_good_out(out_good), .fault_out(fault),
    .unit_inserted_out(inserted), .alert_out(alert), .fw_override(fw_ovr));
  pssc_host pssc_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda));
  // Core clock, 5 ns period
  always #2.5 clock = ~clock;
  task chk(input string nm, input logic [7:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Let pin changes pass the sync stages, then sample off the edge
  task settle;
    repeat (6) @(posedge clock);
    #1;
  endtask : settle
  // One frame: address, then n bytes, then stop
  task send(input logic [7:0] a, p, d, input logic ea, input int n);
    pssc_host_inst.start;
    pssc_host_inst.put(a, ack);
    chk("address ack", ea, ack);
    if (n > 0)
    begin
      pssc_host_inst.put(p, ack);
      chk("pointer ack", 1'b1, ack);
    end
    if (n > 1)
    begin
      pssc_host_inst.put(d, ack);
      chk("data ack", 1'b1, ack);
    end
    pssc_host_inst.stop;
  endtask : send
  // Set pointer, then read one byte into rd
  task fetch(input logic [7:0] a, p);
    send(a, p, 8'h00, 1'b1, 1);
    pssc_host_inst.start;
    pssc_host_inst.put(a | 8'h01, ack);
    pssc_host_inst.get(1'b1, rd);
    pssc_host_inst.stop;
  endtask : fetch
  task t_reset_state;
    chk("inserted", 1'b0, inserted);
    chk("override", 1'b0, fw_ovr);
    chk("main on", 1'b1, main_on);
    chk("alert", 1'b1, alert);
    $display("test reset_state done");
  endtask : t_reset_state
  task t_pins;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      {remote, en_n} <= i[1:0];
      settle;
      chk("main on", i == 2, main_on);
    end
    for (int j = 0; j < 6; j++)
    begin
      @(posedge clock);
      {range, present, ot, ov, oc} <= tbl[j];
      settle;
      chk("input good", tbl[j][4], in_good);
      chk("output good", tbl[j][3], out_good);
      chk("fault", j == 0, fault);
    end
    @(posedge clock);
    {remote, en_n, range, present, ot, ov, oc} <= 7'h58;
    $display("test pins done");
  endtask : t_pins
  task t_addr;
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clock);
      slot <= s[2:0];
      settle;
      send({4'hB, s[2:0], 1'b0}, 8'h00, 8'h00, 1'b1, 0);
      send({4'hA, s[2:0], 1'b0}, 8'h00, 8'h00, 1'b1, 0);
      send({4'hB, ~s[2:0], 1'b0}, 8'h00, 8'h00, 1'b0, 0);
    end
    $display("test addr done");
  endtask : t_addr
  task t_fw;
    send({4'hB, slot, 1'b0}, CMD_ON_OFF, 8'h00, 1'b1, 2);
    settle;
    chk("override", 1'b1, fw_ovr);
    chk("main on", 1'b0, main_on);
    send({4'hB, slot, 1'b0}, CMD_ON_OFF, CMD_FW_ON, 1'b1, 2);
    settle;
    chk("main on", 1'b1, main_on);
    fetch({4'hB, slot, 1'b0}, CMD_ON_OFF);
    chk("on/off byte", CMD_FW_ON, rd);
    @(posedge clock);
    remote <= 1'b0;
    settle;
    chk("main on", 1'b0, main_on);
    @(posedge clock);
    remote <= 1'b1;
    send({4'hB, slot, 1'b0}, CMD_ON_OFF, 8'h00, 1'b1, 2);
    @(posedge clock);
    nrst <= 1'b0;
    settle;
    @(posedge clock);
    nrst <= 1'b1;
    settle;
    chk("override", 1'b0, fw_ovr);
    chk("main on", 1'b1, main_on);
    $display("test fw done");
  endtask : t_fw
  task t_lock;
    @(posedge clock);
    wl <= 1'b0;
    settle;
    send({4'hA, slot, 1'b0}, 8'h10, 8'h5A, 1'b1, 2);
    @(posedge clock);
    wl <= 1'b1;
    settle;
    send({4'hA, slot, 1'b0}, 8'h10, 8'hC3, 1'b1, 2);
    fetch({4'hA, slot, 1'b0}, 8'h10);
    chk("rom byte", 8'h5A, rd);
    // Status byte: input and output good, main on, no override, writes locked
    fetch({4'hB, slot, 1'b0}, 8'h00);
    chk("status byte", 8'hC4, rd);
    $display("test lock done");
  endtask : t_lock
  task t_alert;
    @(posedge clock);
    alert_ev <= 1'b1;
    @(posedge clock);
    alert_ev <= 1'b0;
    settle;
    chk("alert", 1'b0, alert);
    send({4'hB, slot, 1'b0}, 8'h00, 8'h00, 1'b1, 0);
    settle;
    chk("alert", 1'b1, alert);
    $display("test alert done");
  endtask : t_alert
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    settle;
    t_reset_state;
    t_pins;
    t_addr;
    t_fw;
    t_lock;
    t_alert;
    give_verdict;
  end
  // Watchdog, well beyond the expected run time
  initial
  begin
    #200000;
    bad_count++;
    give_verdict;
  end
endmodule : pssc_top_tb_top
